// ===== hw/cfbp_decode.sv
// Destination decoder: turns a pointer code into buffer index or FIFO flag.
// Assumes purely combinational use inside the pointer block.
`timescale 1ns/1ps
module cfbp_decode (
	input  wire logic [3:0] code,
	output logic            to_fifo,
	output logic [3:0]      buf_index
);
	always_comb begin
		to_fifo   = (code == cfbp_pkg::DEST_FIFO_CODE);
		buf_index = to_fifo ? 4'h0 : code;
	end
endmodule // cfbp_decode

// ===== hw/cfbp_pkg.sv
// Package for the CAN filter destination pointer block.
// Assumes one 10 MHz system clock and an AXI4-Lite register bus.
package cfbp_pkg;

	// ****************************************************************
	// Register map (byte addresses)
	// ****************************************************************
	localparam logic [3:0]  ADDR_PTR_4_7    = 4'h0;
	localparam logic [3:0]  ADDR_PTR_12_15  = 4'h4;
	localparam logic [3:0]  ADDR_LOOKUP     = 4'h8;
	localparam logic [3:0]  ADDR_LOOKUP_RES = 4'hC;
	localparam logic [15:0] PTR_RESET       = 16'h0000;

	// ****************************************************************
	// Field layout
	// ****************************************************************
	localparam int          FIELD_W         = 4;
	localparam int          FILTER_W        = 4;
	localparam logic [3:0]  DEST_FIFO_CODE  = 4'hF;
	localparam logic [3:0]  FILTER_LO_BASE  = 4'h4;
	localparam logic [3:0]  FILTER_HI_BASE  = 4'hC;
	localparam logic [1:0]  AXI_OKAY        = 2'h0;
	localparam logic [1:0]  AXI_SLVERR      = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RESP = 3'b010,
		ST_HOLD = 3'b100
	} cfbp_bus_e;

endpackage

// ===== hw/cfbp_top.sv
// CAN filter destination pointer registers for filters 4-7 and 12-15.
// Assumes a synchronous filter-hit strobe from acceptance filtering.
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module cfbp_top (
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic        HIT_VALID,
	input  wire logic [3:0]  HIT_FILTER,
	output logic             DEST_VALID,
	output logic             DEST_FIFO,
	output logic [3:0]       DEST_BUFFER,
	output logic             DEST_UNMAPPED,
	input  wire logic [3:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [3:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY
);

	// ****************************************************************
	// Pointer storage
	// ****************************************************************
	logic [15:0] filter4_to_7_dest_pointer;
	logic [15:0] filter12_to_15_dest_pointer;
	logic [3:0]  lookup_filter;

	// Field helper: nibble n of a 16-bit register
	function automatic logic [3:0] nib(input logic [15:0] r, input logic [1:0] n);
		nib = r[n*cfbp_pkg::FIELD_W +: cfbp_pkg::FIELD_W];
	endfunction

	// Byte-lane merge for the low 16 bits
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Pointer for a filter; filters without a field here report unmapped
	function automatic logic [4:0] ptr_of(input logic [3:0] f);
		if (f[3:2] == cfbp_pkg::FILTER_LO_BASE[3:2])
			ptr_of = {1'b1, nib(filter4_to_7_dest_pointer, f[1:0])};
		else if (f[3:2] == cfbp_pkg::FILTER_HI_BASE[3:2])
			ptr_of = {1'b1, nib(filter12_to_15_dest_pointer, f[1:0])};
		else
			ptr_of = 5'h00;
	endfunction

	wire logic [3:0] filter4_dest_sel  = nib(filter4_to_7_dest_pointer, 2'd0);
	wire logic [3:0] filter5_dest_sel  = nib(filter4_to_7_dest_pointer, 2'd1);
	wire logic [3:0] filter12_dest_sel = nib(filter12_to_15_dest_pointer, 2'd0);
	wire logic [3:0] filter6_dest_sel  = nib(filter4_to_7_dest_pointer, 2'h2);
	wire logic [3:0] filter7_dest_sel  = nib(filter4_to_7_dest_pointer, 2'h3);
	wire logic [3:0] filter13_dest_sel = nib(filter12_to_15_dest_pointer, 2'h1);
	wire logic [3:0] filter14_dest_sel = nib(filter12_to_15_dest_pointer, 2'h2);

	// ****************************************************************
	// Hit decode
	// ****************************************************************
	// Hit comes from logic on MCLK, so no synchroniser is needed.
	logic [4:0] hit_ptr;
	logic       dec_fifo;
	logic [3:0] dec_buf;
	logic [4:0] look_ptr;
	logic       look_fifo;
	logic [3:0] look_buf;

	always_comb hit_ptr = ptr_of(HIT_FILTER);
	always_comb look_ptr = ptr_of(lookup_filter);

	cfbp_decode u_dec (
		.code      (hit_ptr[3:0]),
		.to_fifo   (dec_fifo),
		.buf_index (dec_buf)
	);

	cfbp_decode u_look (
		.code      (look_ptr[3:0]),
		.to_fifo   (look_fifo),
		.buf_index (look_buf)
	);

	// ****************************************************************
	// Destination output
	// ****************************************************************
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			DEST_VALID    <= 1'b0;
			DEST_FIFO     <= 1'b0;
			DEST_BUFFER   <= 4'h0;
			DEST_UNMAPPED <= 1'b0;
		end else if (CE) begin
			DEST_VALID    <= HIT_VALID && hit_ptr[4];
			DEST_UNMAPPED <= HIT_VALID && !hit_ptr[4];
			if (HIT_VALID && hit_ptr[4]) begin
				DEST_FIFO   <= dec_fifo;
				DEST_BUFFER <= dec_buf;
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite write channel
	// ****************************************************************
	// Ready holds its last value while CE is low, so no transfer may be offered then
	logic        aw_held;
	logic        w_held;
	logic [3:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	wire logic   aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
	wire logic   w_take  = S_AXI_WVALID && S_AXI_WREADY;
	wire logic   wr_go   = aw_held && w_held && !S_AXI_BVALID;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 4'h0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
		end else if (CE) begin
			S_AXI_AWREADY <= !aw_held && !aw_take && !S_AXI_BVALID;
			S_AXI_WREADY  <= !w_held && !w_take && !S_AXI_BVALID;
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	// Register writes and write response
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			filter4_to_7_dest_pointer   <= cfbp_pkg::PTR_RESET;
			filter12_to_15_dest_pointer <= cfbp_pkg::PTR_RESET;
			lookup_filter               <= 4'h0;
			S_AXI_BVALID                <= 1'b0;
			S_AXI_BRESP                 <= cfbp_pkg::AXI_OKAY;
		end else if (CE) begin
			if (S_AXI_BVALID && S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
			if (wr_go) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= cfbp_pkg::AXI_OKAY;
				case (aw_addr)
				cfbp_pkg::ADDR_PTR_4_7: begin
					filter4_to_7_dest_pointer <= merge(filter4_to_7_dest_pointer, w_data, w_strb);
				end
				cfbp_pkg::ADDR_PTR_12_15: begin
					filter12_to_15_dest_pointer <= merge(filter12_to_15_dest_pointer, w_data, w_strb);
				end
				cfbp_pkg::ADDR_LOOKUP: begin
					if (w_strb[0])
						lookup_filter <= w_data[cfbp_pkg::FILTER_W-1:0];
				end
				cfbp_pkg::ADDR_LOOKUP_RES: begin
					S_AXI_BRESP <= cfbp_pkg::AXI_SLVERR;
				end
				default: begin
					S_AXI_BRESP <= cfbp_pkg::AXI_SLVERR;
				end
				endcase
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	cfbp_pkg::cfbp_bus_e rd_state;
	logic [31:0]         next_rdata;
	logic [1:0]          next_rresp;

	always_comb begin
		next_rresp = cfbp_pkg::AXI_OKAY;
		case (S_AXI_ARADDR)
		cfbp_pkg::ADDR_PTR_4_7:    next_rdata = {16'h0000, filter4_to_7_dest_pointer};
		cfbp_pkg::ADDR_PTR_12_15:  next_rdata = {16'h0000, filter12_to_15_dest_pointer};
		cfbp_pkg::ADDR_LOOKUP:     next_rdata = {28'h000_0000, lookup_filter};
		cfbp_pkg::ADDR_LOOKUP_RES: next_rdata = {25'h000_0000, look_ptr[4], look_fifo, 1'b0, look_buf};
		default: begin
			next_rdata = 32'h0000_0000;
			next_rresp = cfbp_pkg::AXI_SLVERR;
		end
		endcase
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			rd_state      <= cfbp_pkg::ST_IDLE;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0000_0000;
			S_AXI_RRESP   <= cfbp_pkg::AXI_OKAY;
		end else if (CE) begin
			case (rd_state)
			cfbp_pkg::ST_IDLE: begin
				S_AXI_ARREADY <= 1'b1;
				if (S_AXI_ARVALID && S_AXI_ARREADY) begin
					S_AXI_ARREADY <= 1'b0;
					S_AXI_RVALID  <= 1'b1;
					S_AXI_RDATA   <= next_rdata;
					S_AXI_RRESP   <= next_rresp;
					rd_state      <= cfbp_pkg::ST_RESP;
				end
			end
			cfbp_pkg::ST_RESP: begin
				S_AXI_ARREADY <= 1'b0;
				if (S_AXI_RREADY) begin
					S_AXI_RVALID <= 1'b0;
					rd_state     <= cfbp_pkg::ST_HOLD;
				end
			end
			cfbp_pkg::ST_HOLD: begin
				rd_state <= cfbp_pkg::ST_IDLE;
			end
			default: begin
				rd_state <= cfbp_pkg::ST_IDLE;
			end
			endcase
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_fifo_code: assert property (@(posedge MCLK) disable iff (RST)
		CE && HIT_VALID && hit_ptr[4] && hit_ptr[3:0] == cfbp_pkg::DEST_FIFO_CODE
		|=> DEST_VALID && DEST_FIFO)
		else $error("FIFO code did not select FIFO");
	a_buffer_code: assert property (@(posedge MCLK) disable iff (RST)
		CE && HIT_VALID && hit_ptr[4] && hit_ptr[3:0] != cfbp_pkg::DEST_FIFO_CODE
		|=> DEST_VALID && !DEST_FIFO && DEST_BUFFER == $past(hit_ptr[3:0]))
		else $error("Buffer code mismatch");
	a_filter4_field: assert property (@(posedge MCLK) disable iff (RST)
		CE && HIT_VALID && HIT_FILTER == 4'h4 && filter4_dest_sel != cfbp_pkg::DEST_FIFO_CODE
		|=> DEST_BUFFER == $past(filter4_to_7_dest_pointer[3:0]))
		else $error("Filter 4 field wrong");
	a_filter5_field: assert property (@(posedge MCLK) disable iff (RST)
		CE && HIT_VALID && HIT_FILTER == 4'h5 && filter5_dest_sel != cfbp_pkg::DEST_FIFO_CODE
		|=> DEST_BUFFER == $past(filter4_to_7_dest_pointer[7:4]))
		else $error("Filter 5 field wrong");
	a_filter12_field: assert property (@(posedge MCLK) disable iff (RST)
		CE && HIT_VALID && HIT_FILTER == 4'hC && filter12_dest_sel != cfbp_pkg::DEST_FIFO_CODE
		|=> DEST_BUFFER == $past(filter12_to_15_dest_pointer[3:0]))
		else $error("Filter 12 field wrong");
	a_filter6_field: assert property (@(posedge MCLK) disable iff (RST)
		CE && HIT_VALID && HIT_FILTER == 4'h6 && filter6_dest_sel != cfbp_pkg::DEST_FIFO_CODE
		|=> DEST_BUFFER == $past(filter4_to_7_dest_pointer[11:8]))
		else $error("Filter 6 field wrong");
	a_filter7_field: assert property (@(posedge MCLK) disable iff (RST)
		CE && HIT_VALID && HIT_FILTER == 4'h7 && filter7_dest_sel != cfbp_pkg::DEST_FIFO_CODE
		|=> DEST_BUFFER == $past(filter4_to_7_dest_pointer[15:12]))
		else $error("Filter 7 field wrong");
	a_filter13_field: assert property (@(posedge MCLK) disable iff (RST)
		CE && HIT_VALID && HIT_FILTER == 4'hD && filter13_dest_sel != cfbp_pkg::DEST_FIFO_CODE
		|=> DEST_BUFFER == $past(filter12_to_15_dest_pointer[7:4]))
		else $error("Filter 13 field wrong");
	a_filter14_field: assert property (@(posedge MCLK) disable iff (RST)
		CE && HIT_VALID && HIT_FILTER == 4'hE && filter14_dest_sel != cfbp_pkg::DEST_FIFO_CODE
		|=> DEST_BUFFER == $past(filter12_to_15_dest_pointer[11:8]))
		else $error("Filter 14 field wrong");
	a_filter15_field: assert property (@(posedge MCLK) disable iff (RST)
		CE && HIT_VALID && HIT_FILTER == 4'hF
		|=> DEST_FIFO == ($past(filter12_to_15_dest_pointer[15:12]) == cfbp_pkg::DEST_FIFO_CODE))
		else $error("Filter 15 field wrong");
	a_write_lands: assert property (@(posedge MCLK) disable iff (RST)
		CE && wr_go && aw_addr == cfbp_pkg::ADDR_PTR_4_7 && w_strb[1:0] == 2'b11
		|=> filter4_to_7_dest_pointer == $past(w_data[15:0]))
		else $error("Pointer write lost");
	a_read_back: assert property (@(posedge MCLK) disable iff (RST)
		CE && S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == cfbp_pkg::ADDR_PTR_12_15
		|=> S_AXI_RVALID && S_AXI_RDATA[15:0] == $past(filter12_to_15_dest_pointer))
		else $error("Pointer readback wrong");

endmodule // cfbp_top

// ===== tb/tb_cfbp_top.sv
// Self-checking bench for the CAN filter destination pointer block.
// Assumes cfbp_top carries its own assertions; the bench drives every port itself.
`timescale 1ns/1ps
module tb_cfbp_top;
	// ****************************************************************
	// Signals and instance
	// ****************************************************************
	logic        mclk, rst, ce, hit_valid, awvalid, wvalid, bready, arvalid, rready;
	logic [3:0]  hit_filter, awaddr, wstrb, araddr;
	logic [31:0] wdata;
	logic        dest_valid, dest_fifo, dest_unmapped, awready, wready, bvalid, arready, rvalid;
	logic [3:0]  dest_buffer;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          num_errors, samples_checked;

	cfbp_top cfbp_top_i (
		.MCLK(mclk), .RST(rst), .CE(ce), .HIT_VALID(hit_valid), .HIT_FILTER(hit_filter),
		.DEST_VALID(dest_valid), .DEST_FIFO(dest_fifo), .DEST_BUFFER(dest_buffer), .DEST_UNMAPPED(dest_unmapped),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
	);

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		samples_checked++;
		if (got !== ex) begin
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
			num_errors++;
		end
	endtask

	// Address and data offered together, each dropped once taken
	// No latency assumed: only the watchdog ends a wait that never answers
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge mclk);
			if (awready === 1'h1) awvalid <= 1'h0;
			if (wready === 1'h1) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		bready <= 1'h0;
		chk("bresp", 32'(er), 32'(bresp));
	endtask

	task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge mclk);
			if (arready === 1'h1) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rready <= 1'h0;
		chk("rdata", ed, rdata);
		chk("rresp", 32'(er), 32'(rresp));
	endtask

	// One-cycle hit, result looked at after the edge that answers it
	task automatic hit(input logic [3:0] f, input logic ev, input logic eu, input logic ef, input logic [3:0] eb);
		@(posedge mclk);
		hit_valid <= 1'h1;
		hit_filter <= f;
		@(posedge mclk);
		hit_valid <= 1'h0;
		#1;
		chk("dest_valid", 32'(ev), 32'(dest_valid));
		chk("dest_unmapped", 32'(eu), 32'(dest_unmapped));
		if (ev) begin
			chk("dest_fifo", 32'(ef), 32'(dest_fifo));
			chk("dest_buffer", 32'(eb), 32'(dest_buffer));
		end
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset_values();
		axi_rd(cfbp_pkg::ADDR_PTR_4_7, 32'h0000_0000, cfbp_pkg::AXI_OKAY);
		axi_rd(cfbp_pkg::ADDR_PTR_12_15, 32'h0000_0000, cfbp_pkg::AXI_OKAY);
		hit(4'h6, 1'h1, 1'h0, 1'h0, 4'h0);
		hit(4'hD, 1'h1, 1'h0, 1'h0, 4'h0);
	endtask

	task automatic t_filter7_codes();
		for (int c = 0; c < 16; c++) begin
			axi_wr(cfbp_pkg::ADDR_PTR_4_7, 32'(c) << 12, 4'hF, cfbp_pkg::AXI_OKAY);
			hit(4'h7, 1'h1, 1'h0, c == 15, (c == 15) ? 4'h0 : 4'(c));
		end
	endtask

	task automatic t_lower_register();
		axi_wr(cfbp_pkg::ADDR_PTR_4_7, 32'h0000_3A5C, 4'h3, cfbp_pkg::AXI_OKAY);
		axi_rd(cfbp_pkg::ADDR_PTR_4_7, 32'h0000_3A5C, cfbp_pkg::AXI_OKAY);
		hit(4'h4, 1'h1, 1'h0, 1'h0, 4'hC);
		hit(4'h5, 1'h1, 1'h0, 1'h0, 4'h5);
		hit(4'h6, 1'h1, 1'h0, 1'h0, 4'hA);
		hit(4'h7, 1'h1, 1'h0, 1'h0, 4'h3);
	endtask

	task automatic t_upper_register();
		axi_wr(cfbp_pkg::ADDR_PTR_12_15, 32'hFFFF_E10F, 4'hF, cfbp_pkg::AXI_OKAY);
		axi_rd(cfbp_pkg::ADDR_PTR_12_15, 32'h0000_E10F, cfbp_pkg::AXI_OKAY);
		hit(4'hC, 1'h1, 1'h0, 1'h1, 4'h0);
		hit(4'hD, 1'h1, 1'h0, 1'h0, 4'h0);
		hit(4'hE, 1'h1, 1'h0, 1'h0, 4'h1);
		hit(4'hF, 1'h1, 1'h0, 1'h0, 4'hE);
	endtask

	// Upper byte lane only
	task automatic t_byte_lane();
		axi_wr(cfbp_pkg::ADDR_PTR_12_15, 32'h0000_2B77, 4'h2, cfbp_pkg::AXI_OKAY);
		axi_rd(cfbp_pkg::ADDR_PTR_12_15, 32'h0000_2B0F, cfbp_pkg::AXI_OKAY);
		hit(4'hE, 1'h1, 1'h0, 1'h0, 4'hB);
	endtask

	task automatic t_unmapped();
		hit(4'h0, 1'h0, 1'h1, 1'h0, 4'h0);
		hit(4'hB, 1'h0, 1'h1, 1'h0, 4'h0);
		axi_wr(cfbp_pkg::ADDR_LOOKUP_RES, 32'h0000_0000, 4'hF, cfbp_pkg::AXI_SLVERR);
		axi_wr(4'h6, 32'h0000_FFFF, 4'hF, cfbp_pkg::AXI_SLVERR);
		axi_rd(4'h2, 32'h0000_0000, cfbp_pkg::AXI_SLVERR);
		axi_rd(cfbp_pkg::ADDR_PTR_12_15, 32'h0000_2B0F, cfbp_pkg::AXI_OKAY);
	endtask

	// Lookup result: bit 6 mapped, bit 5 FIFO, bits 3:0 buffer
	task automatic t_lookup();
		axi_wr(cfbp_pkg::ADDR_LOOKUP, 32'h0000_000E, 4'hF, cfbp_pkg::AXI_OKAY);
		axi_rd(cfbp_pkg::ADDR_LOOKUP, 32'h0000_000E, cfbp_pkg::AXI_OKAY);
		axi_rd(cfbp_pkg::ADDR_LOOKUP_RES, 32'h0000_004B, cfbp_pkg::AXI_OKAY);
		axi_wr(cfbp_pkg::ADDR_LOOKUP, 32'h0000_000C, 4'hF, cfbp_pkg::AXI_OKAY);
		axi_rd(cfbp_pkg::ADDR_LOOKUP_RES, 32'h0000_0060, cfbp_pkg::AXI_OKAY);
		axi_wr(cfbp_pkg::ADDR_LOOKUP, 32'h0000_0002, 4'hF, cfbp_pkg::AXI_OKAY);
		axi_rd(cfbp_pkg::ADDR_LOOKUP_RES, 32'h0000_0000, cfbp_pkg::AXI_OKAY);
	endtask

	task automatic t_clock_enable();
		@(posedge mclk);
		ce <= 1'h0;
		hit(4'h4, 1'h0, 1'h0, 1'h0, 4'h0);
		@(posedge mclk);
		ce <= 1'h1;
		hit(4'h4, 1'h1, 1'h0, 1'h0, 4'hC);
	endtask

	task automatic t_mid_reset();
		@(posedge mclk);
		rst <= 1'h1;
		repeat (3) @(posedge mclk);
		rst <= 1'h0;
		t_reset_values();
		hit(4'h5, 1'h1, 1'h0, 1'h0, 4'h0);
		axi_rd(cfbp_pkg::ADDR_LOOKUP, 32'h0000_0000, cfbp_pkg::AXI_OKAY);
	endtask

	// ****************************************************************
	// Clock, watchdog and main sequence
	// ****************************************************************
	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end

	// Whole run is a few hundred cycles
	initial begin
		repeat (3000) @(posedge mclk);
		num_errors++;
		stop_test();
	end

	initial begin
		num_errors = 0;
		samples_checked = 0;
		{rst, ce} = 2'h3;
		{hit_valid, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{hit_filter, awaddr, wstrb, araddr} = 16'h0000;
		wdata = 32'h0000_0000;
		repeat (20) @(posedge mclk);
		rst <= 1'h0;
		t_reset_values();
		t_filter7_codes();
		t_lower_register();
		t_upper_register();
		t_byte_lane();
		t_unmapped();
		t_lookup();
		t_clock_enable();
		t_mid_reset();
		stop_test();
	end
endmodule // tb_cfbp_top
